// ==== include/crit_msi_defs.svh ====
// offsets, field positions, reset values and widths of the critical error msi registers
`ifndef CRIT_MSI_DEFS_SVH
`define CRIT_MSI_DEFS_SVH

// register byte offsets
`define CRIT_MSI_ADDR_LO_OFS 12'hEA0
`define CRIT_MSI_ADDR_HI_OFS 12'hEA4
`define CRIT_MSI_PAYLOAD_OFS 12'hEA8
`define CRIT_MSI_CONTROL_OFS 12'hEAC
`define CRIT_MSI_OFS_W 12
`define CRIT_MSI_WORD_SEL_LSB 2
`define CRIT_MSI_BASE_IDX 10'h3A8

// address field
`define CRIT_MSI_ADDR_FIELD_LSB 2
`define CRIT_MSI_ADDR_FIELD_MSB 55
`define CRIT_MSI_ADDR_W 56

// control register fields
`define CRIT_MSI_EN_BIT 7
`define CRIT_MSI_NS_BIT 6
`define CRIT_MSI_SH_LSB 4
`define CRIT_MSI_SH_MSB 5
`define CRIT_MSI_MT_LSB 0
`define CRIT_MSI_MT_MSB 3

// shareability and memory type codes
`define CRIT_MSI_SH_NONE 2'h0
`define CRIT_MSI_SH_OUTER 2'h2
`define CRIT_MSI_SH_INNER 2'h3
`define CRIT_MSI_MT_DEVICE_TOP 2'h0
`define CRIT_MSI_MT_NORMAL_NC 4'h5

// reset values
`define CRIT_MSI_WORD_RESET 32'h0000_0000
`define CRIT_MSI_EN_RESET 1'b0

`endif

// ==== include/crit_msi_pkg.sv ====
// types shared by the critical error msi configuration block
package crit_msi_pkg;

  // attributes that travel with one interrupt write
  typedef struct packed {
    logic ns;
    logic [1:0] sh;
    logic [3:0] mt;
  } msi_attr_s;

  // one interrupt write as offered to the interconnect
  typedef struct packed {
    logic [55:0] addr;
    logic [31:0] data;
    msi_attr_s attr;
  } msi_req_s;

  // write issuer states, gray along idle -> send -> done
  typedef enum logic [1:0] {
    ISSUE_IDLE = 2'b00,
    ISSUE_SEND = 2'b01,
    ISSUE_DONE = 2'b11
  } issue_state_e;

endpackage

// ==== design/crit_msi_attr_resolve.sv ====
// works out the attributes that an interrupt write really uses
`timescale 1ns/1ps
`include "crit_msi_defs.svh"
module crit_msi_attr_resolve #(
  parameter bit SEC_CFG = 1'b1,
  parameter bit NS_WRITE_OK = 1'b0,
  parameter bit SEC_FIXED = 1'b1,
  parameter bit SH_CFG = 1'b1,
  parameter logic [1:0] SH_FIXED = 2'h2,
  parameter bit MT_CFG = 1'b1,
  parameter logic [3:0] MT_FIXED = 4'h0
) (
  // programmed control word
  input wire logic [31:0] i_control,
  // resolved attributes
  output crit_msi_pkg::msi_attr_s o_attr
);
  logic [3:0] mt_eff;
  logic [1:0] sh_eff;
  logic ns_eff;

  always_comb begin
    // outside the custom layout a non-secure writer may never steer writes into secure space
    if (NS_WRITE_OK) begin
      ns_eff = 1'b1;
    end else if (SEC_CFG) begin
      ns_eff = i_control[`CRIT_MSI_NS_BIT];
    end else begin
      ns_eff = SEC_FIXED;
    end
    mt_eff = MT_CFG ? i_control[`CRIT_MSI_MT_MSB:`CRIT_MSI_MT_LSB] : MT_FIXED;
    sh_eff = SH_CFG ? i_control[`CRIT_MSI_SH_MSB:`CRIT_MSI_SH_LSB] : SH_FIXED;
    // device or fully non-cacheable normal memory is outer shareable
    if (mt_eff[3:2] == `CRIT_MSI_MT_DEVICE_TOP || mt_eff == `CRIT_MSI_MT_NORMAL_NC) begin
      sh_eff = `CRIT_MSI_SH_OUTER;
    end
    o_attr.ns = ns_eff;
    o_attr.sh = sh_eff;
    o_attr.mt = mt_eff;
  end
endmodule // crit_msi_attr_resolve

// ==== design/crit_msi_issuer.sv ====
// issues one interrupt write per enabled critical error not already pending, and holds it until accepted
`timescale 1ns/1ps
module crit_msi_issuer (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // event side
  input wire logic i_event,
  input wire logic i_enable,
  input crit_msi_pkg::msi_req_s i_req,
  // interconnect side
  input wire logic i_msi_ready,
  output logic o_msi_valid,
  output crit_msi_pkg::msi_req_s o_msi_req,
  output logic o_busy
);
  typedef struct packed {
    crit_msi_pkg::issue_state_e state;
    logic pending;
    logic valid;
    logic busy;
    crit_msi_pkg::msi_req_s req;
  } issue_state_s;

  issue_state_s st_r;
  issue_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      crit_msi_pkg::ISSUE_IDLE: begin
        if (st_r.pending) begin
          // payload and attributes are sampled at launch, not at the event
          st_nxt.req = i_req;
          st_nxt.valid = 1'b1;
          st_nxt.pending = 1'b0;
          st_nxt.state = crit_msi_pkg::ISSUE_SEND;
        end
      end
      crit_msi_pkg::ISSUE_SEND: begin
        if (i_msi_ready) begin
          st_nxt.valid = 1'b0;
          st_nxt.state = crit_msi_pkg::ISSUE_DONE;
        end
      end
      crit_msi_pkg::ISSUE_DONE: begin
        st_nxt.state = crit_msi_pkg::ISSUE_IDLE;
      end
      default: begin
        st_nxt.state = crit_msi_pkg::ISSUE_IDLE;
        st_nxt.valid = 1'b0;
      end
    endcase
    // an event in the launch cycle stays pending: set beats clear
    if (i_event && i_enable) begin
      st_nxt.pending = 1'b1;
    end
    // registered from the next state so the busy port comes from a flop
    st_nxt.busy = st_nxt.pending || (st_nxt.state != crit_msi_pkg::ISSUE_IDLE);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_msi_valid = st_r.valid;
  assign o_msi_req = st_r.req;
  assign o_busy = st_r.busy;
endmodule // crit_msi_issuer

// ==== design/crit_msi_config.sv ====
// critical error msi configuration registers and interrupt write launch
`timescale 1ns/1ps
`include "crit_msi_defs.svh"
module crit_msi_config #(
  parameter int PA_BITS = 48,
  parameter bit IRQ_CFG_PRESENT = 1'b1,
  parameter bit CRIT_IRQ_PRESENT = 1'b1,
  parameter bit RECOMMENDED_LAYOUT = 1'b1,
  parameter bit EN_SUPPORT = 1'b1,
  parameter bit SEC_CFG = 1'b1,
  parameter bit NS_WRITE_OK = 1'b0,
  parameter bit SEC_RESET = 1'b0,
  parameter bit SEC_FIXED = 1'b1,
  parameter bit SH_CFG = 1'b1,
  parameter logic [1:0] SH_FIXED = 2'h2,
  parameter bit MT_CFG = 1'b1,
  parameter logic [3:0] MT_FIXED = 4'h0
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // register access port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_ns,
  input wire logic [`CRIT_MSI_OFS_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // error event
  input wire logic i_crit_err,
  // interrupt write to the interconnect
  input wire logic i_msi_ready,
  output logic o_msi_valid,
  output logic [`CRIT_MSI_ADDR_W-1:0] o_msi_addr,
  output logic [31:0] o_msi_data,
  output logic o_msi_ns,
  output logic [1:0] o_msi_sh,
  output logic [3:0] o_msi_mt,
  output logic o_msi_busy
);
  localparam int NWORDS = 4;
  localparam bit PRESENT = IRQ_CFG_PRESENT && (CRIT_IRQ_PRESENT || !RECOMMENDED_LAYOUT);
  localparam bit STD = PRESENT && RECOMMENDED_LAYOUT;
  localparam bit CUSTOM = PRESENT && !RECOMMENDED_LAYOUT;
  localparam logic [`CRIT_MSI_OFS_W-1:0] BASE_OFS = `CRIT_MSI_ADDR_LO_OFS;

  // implemented address bits: field 55:2 cut down to the physical size
  localparam logic [63:0] PA_TOP = (PA_BITS >= `CRIT_MSI_ADDR_W) ?
    64'hFFFF_FFFF_FFFF_FFFF : ((64'h0000_0000_0000_0001 << PA_BITS) - 64'h0000_0000_0000_0001);
  localparam logic [63:0] ADDR_MASK = PA_TOP & 64'h00FF_FFFF_FFFF_FFFC;

  // writable bits of the control word
  localparam logic [31:0] CTRL_MASK = {24'h00_0000,
    EN_SUPPORT,
    SEC_CFG && !NS_WRITE_OK,
    {2{SH_CFG}}, {4{MT_CFG}}};
  localparam logic [31:0] CTRL_RESET = {24'h00_0000, `CRIT_MSI_EN_RESET,
    SEC_RESET && SEC_CFG && !NS_WRITE_OK, 6'h00};

  // per word write masks; a custom layout keeps every bit as plain storage
  localparam logic [NWORDS-1:0][31:0] WMASK = CUSTOM ? {4{32'hFFFF_FFFF}} :
    STD ? {CTRL_MASK, 32'hFFFF_FFFF, ADDR_MASK[63:32], ADDR_MASK[31:0]} :
    {4{32'h0000_0000}};
  localparam logic [NWORDS-1:0][31:0] WRESET = {CTRL_RESET, {3{`CRIT_MSI_WORD_RESET}}};

  typedef struct packed {
    logic [NWORDS-1:0][31:0] word;
    logic [31:0] rdata;
    logic rvalid;
  } cfg_state_s;

  cfg_state_s st_r;
  cfg_state_s st_nxt;

  logic in_window;
  logic [1:0] word_sel;
  logic [NWORDS-1:0] word_hit;
  logic [NWORDS-1:0][31:0] word_wr;
  logic ctrl_refused;
  crit_msi_pkg::msi_attr_s attr_eff;
  crit_msi_pkg::msi_req_s req_now;
  crit_msi_pkg::msi_req_s req_out;
  logic gen_enable;

  // the four words sit in one aligned 16-byte window
  assign in_window = (i_reg_addr[`CRIT_MSI_OFS_W-1:`CRIT_MSI_WORD_SEL_LSB+2] ==
    BASE_OFS[`CRIT_MSI_OFS_W-1:`CRIT_MSI_WORD_SEL_LSB+2]);
  assign word_sel = i_reg_addr[`CRIT_MSI_WORD_SEL_LSB+1:`CRIT_MSI_WORD_SEL_LSB];

  // protected control: in the recommended layout a non-secure writer cannot change the control word, though it can still write the address words
  assign ctrl_refused = i_reg_ns && SEC_CFG && !NS_WRITE_OK;

  genvar gi;
  generate
    for (gi = 0; gi < NWORDS; gi++) begin : g_word
      logic refused;
      assign refused = (gi == NWORDS - 1) && ctrl_refused && STD;
      assign word_hit[gi] = i_reg_wr && in_window && (word_sel == gi) && !refused;
      // only writable bits take the new value; the rest keep their reset value
      assign word_wr[gi] = (i_reg_wdata & WMASK[gi]) | (st_r.word[gi] & ~WMASK[gi]);
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    for (int k = 0; k < NWORDS; k++) begin
      if (word_hit[k]) begin
        st_nxt.word[k] = word_wr[k];
      end
    end
    // reads answer one cycle later; unmapped offsets read zero
    st_nxt.rvalid = i_reg_rd;
    st_nxt.rdata = 32'h0000_0000;
    if (i_reg_rd && in_window) begin
      st_nxt.rdata = st_r.word[word_sel] & WMASK[word_sel];
    end
  end

  // unknown reset values are held at zero so simulation stays defined
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r.word <= WRESET;
      st_r.rdata <= 32'h0000_0000;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  crit_msi_attr_resolve #(
    .SEC_CFG(SEC_CFG),
    .NS_WRITE_OK(NS_WRITE_OK),
    .SEC_FIXED(SEC_FIXED),
    .SH_CFG(SH_CFG),
    .SH_FIXED(SH_FIXED),
    .MT_CFG(MT_CFG),
    .MT_FIXED(MT_FIXED)
  ) u_attr (
    .i_control(st_r.word[NWORDS-1]),
    .o_attr(attr_eff)
  );

  // the written address is the field shifted left two places
  assign req_now.addr = {st_r.word[1][23:0], st_r.word[0][31:2], 2'b00};
  assign req_now.data = st_r.word[2];
  assign req_now.attr = attr_eff;
  assign gen_enable = PRESENT && CRIT_IRQ_PRESENT &&
    (EN_SUPPORT ? st_r.word[NWORDS-1][`CRIT_MSI_EN_BIT] : 1'b1);

  crit_msi_issuer u_issue (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_event(i_crit_err),
    .i_enable(gen_enable),
    .i_req(req_now),
    .i_msi_ready(i_msi_ready),
    .o_msi_valid(o_msi_valid),
    .o_msi_req(req_out),
    .o_busy(o_msi_busy)
  );

  assign o_msi_addr = req_out.addr;
  assign o_msi_data = req_out.data;
  assign o_msi_ns = req_out.attr.ns;
  assign o_msi_sh = req_out.attr.sh;
  assign o_msi_mt = req_out.attr.mt;
  assign o_reg_rdata = st_r.rdata;
  assign o_reg_rvalid = st_r.rvalid;
endmodule // crit_msi_config

// ==== tb/crit_msi_config_sva.sv ====
// port assertions for the critical error msi configuration block
`timescale 1ns/1ps
module crit_msi_config_sva #(
  parameter int PA_BITS = 48
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // watched ports
  input wire logic i_reg_rd,
  input wire logic i_msi_ready,
  input wire logic o_reg_rvalid,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_msi_valid,
  input wire logic [55:0] o_msi_addr,
  input wire logic [31:0] o_msi_data,
  input wire logic [1:0] o_msi_sh,
  input wire logic [3:0] o_msi_mt,
  input wire logic o_msi_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_addr_align: assert property (o_msi_valid |-> o_msi_addr[1:0] == 2'h0)
    else $error("write address not word aligned");
  a_addr_range: assert property (o_msi_valid |-> (o_msi_addr >> PA_BITS) == 56'h0)
    else $error("write address above physical size");
  a_share_forced: assert property (o_msi_valid && (o_msi_mt[3:2] == 2'h0
    || o_msi_mt == 4'h5) |-> o_msi_sh == 2'h2)
    else $error("device or uncached write not outer shareable");
  a_req_hold: assert property (o_msi_valid && !i_msi_ready |=> o_msi_valid
    && $stable(o_msi_addr) && $stable(o_msi_data))
    else $error("write changed before acceptance");
  a_req_drop: assert property (o_msi_valid && i_msi_ready |=> !o_msi_valid)
    else $error("write still offered after acceptance");
  a_launch_busy: assert property ($rose(o_msi_valid) |-> $past(o_msi_busy))
    else $error("write launched without pending event");
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without read");
  a_rdata_idle: assert property (!o_reg_rvalid |-> o_reg_rdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  c_accept: cover property (o_msi_valid && i_msi_ready);
  c_stall: cover property (o_msi_valid && !i_msi_ready);
  c_read: cover property (o_reg_rvalid);
endmodule // crit_msi_config_sva

// ==== tb/crit_msi_sink.sv ====
// far side model: takes interrupt writes after a chosen stall
`timescale 1ns/1ps
module crit_msi_sink (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // stall length from the bench
  input wire logic [3:0] i_delay,
  // interrupt write
  input wire logic i_valid,
  input crit_msi_pkg::msi_req_s i_req,
  output logic o_ready,
  output logic [7:0] o_count,
  output crit_msi_pkg::msi_req_s o_last
);
  logic [3:0] wait_r;
  // ready only after the stall, so slow acceptance is exercised too
  assign o_ready = i_valid && (wait_r >= i_delay);
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_r <= 4'h0;
      o_count <= 8'h00;
      o_last <= '0;
    end else if (o_ready) begin
      wait_r <= 4'h0;
      o_count <= o_count + 8'h01;
      o_last <= i_req;
    end else if (i_valid) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // crit_msi_sink

// ==== tb/critical_error_msi_config_tb.sv ====
// self-checking bench for the critical error msi configuration block
`timescale 1ns/1ps
module critical_error_msi_config_tb;
  localparam int PA = 48;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_reg_ns = 1'b0, i_crit_err = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic [31:0] i_reg_wdata = 32'h0000_0000, o_reg_rdata, o_msi_data;
  logic o_reg_rvalid, i_msi_ready, o_msi_valid, o_msi_ns, o_msi_busy;
  logic [55:0] o_msi_addr;
  logic [1:0] o_msi_sh, e_sh;
  logic [3:0] o_msi_mt, m, delay = 4'h0;
  logic [7:0] count, c;
  crit_msi_pkg::msi_req_s seen, req;
  int fails = 0, comparisons = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  crit_msi_config #(.PA_BITS(PA)) u_dut (.i_sys_clk, .i_resetn, .i_reg_wr, .i_reg_rd,
    .i_reg_ns, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_crit_err,
    .i_msi_ready, .o_msi_valid, .o_msi_addr, .o_msi_data, .o_msi_ns, .o_msi_sh,
    .o_msi_mt, .o_msi_busy);
  assign req = {o_msi_addr, o_msi_data, o_msi_ns, o_msi_sh, o_msi_mt};
  crit_msi_sink u_sink (.i_sys_clk, .i_resetn, .i_delay(delay), .i_valid(o_msi_valid),
    .i_req(req), .o_ready(i_msi_ready), .o_count(count), .o_last(seen));
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_ns <= ns;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
    i_reg_ns <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk({o_reg_rvalid, o_reg_rdata}, {1'b1, e});
  endtask
  // pulse one event, then wait a bounded time for the sink count to reach n
  task automatic fire(input logic [7:0] n);
    int k;
    @(posedge i_sys_clk);
    i_crit_err <= 1'b1;
    @(posedge i_sys_clk);
    i_crit_err <= 1'b0;
    // an enabled event must leave the block busy once it is taken
    @(negedge i_sys_clk);
    chk(o_msi_busy, n != count);
    for (k = 0; k < 40 && count != n; k++) @(posedge i_sys_clk);
    if (count != n) begin
      fails++;
      finish_test();
    end
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(12'hEA8, 32'h0000_0000);
    rd(12'hEAC, 32'h0000_0000);
    $display("test reset done");
    wr(12'hEA0, 32'hFFFF_FFFF, 1'b0);
    rd(12'hEA0, 32'hFFFF_FFFC);
    wr(12'hEA4, 32'hFFFF_FFFF, 1'b0);
    rd(12'hEA4, 32'((64'h1 << (PA - 32)) - 1));
    wr(12'hEAC, 32'hFFFF_FFFF, 1'b0);
    rd(12'hEAC, 32'h0000_00FF);
    wr(12'hEAC, 32'h0000_0000, 1'b1);
    rd(12'hEAC, 32'h0000_00FF);
    wr(12'hEA8, 32'h1234_5678, 1'b0);
    rd(12'hEA8, 32'h1234_5678);
    rd(12'hEB0, 32'h0000_0000);
    $display("test registers done");
    wr(12'hEA0, 32'h0000_1000, 1'b0);
    wr(12'hEA4, 32'h0000_0001, 1'b0);
    // every memory type code, both spaces, prompt and stalled sink
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      e_sh = (m[3:2] == 2'h0 || m == 4'h5) ? 2'h2 : 2'h3;
      delay <= 4'(i % 5);
      wr(12'hEAC, {24'h00_0000, 1'b1, m[0], 2'h3, m}, 1'b0);
      fire(count + 8'h01);
      chk(seen, {56'h1_0000_1000, 32'h1234_5678, m[0], e_sh, m});
    end
    $display("test events done");
    wr(12'hEAC, 32'h0000_0037, 1'b0);
    c = count;
    fire(c);
    repeat (10) @(posedge i_sys_clk);
    chk({count, o_msi_valid, o_msi_busy}, {c, 2'b00});
    $display("test disable done");
    finish_test();
  end
endmodule // critical_error_msi_config_tb
bind crit_msi_config crit_msi_config_sva #(.PA_BITS(PA_BITS)) u_sva (.i_sys_clk, .i_resetn,
  .i_reg_rd, .i_msi_ready, .o_reg_rvalid, .o_reg_rdata, .o_msi_valid, .o_msi_addr,
  .o_msi_data, .o_msi_sh, .o_msi_mt, .o_msi_busy);
